// *** ihp_map.svh ***
// offsets, field positions, reset values and counts of the idle/halt power controller
`ifndef IHP_MAP_SVH
`define IHP_MAP_SVH

// register addresses on the plain register port
`define IHP_ADDR_PORTG 4'h0
`define IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER 4'h1
`define IHP_ADDR_INTERRUPT_CONTROL_REGISTER 4'h2
`define IHP_ADDR_STATUS 4'h3

// port g data register fields
`define IHP_PG_IDLE 6
`define IHP_PG_HALT 7

// idle timer control register fields
`define IHP_IT_LOW_OSC_ON 7
`define IHP_IT_HIGH_OSC_ON 6
`define IHP_IT_DUAL_CLOCK_EN 5
`define IHP_IT_CORE_CLK_SEL 4
`define IHP_IT_WIN_MSB 2
`define IHP_IT_WIN_LSB 0
`define IHP_IT_WRITE_MASK 8'hF7
`define IHP_IT_RESET 8'h40

// valid contents of the four clock control bits
`define IHP_CLK_HS 4'h4
`define IHP_CLK_HS_TO_DC 4'hC
`define IHP_CLK_DC 4'hE
`define IHP_CLK_DC_TO_LS 4'hF
`define IHP_CLK_LS 4'hB

// interrupt control register fields
`define IHP_IC_ENABLE 0
`define IHP_IC_PENDING 1

// timing counts
`define IHP_INSTR_DIV_LAST 3'h4
`define IHP_STARTUP_COUNT 16'h0100
`define IHP_WIN_MASK_4K 16'h0FFF
`define IHP_WIN_MASK_8K 16'h1FFF
`define IHP_WIN_MASK_16K 16'h3FFF
`define IHP_WIN_MASK_32K 16'h7FFF
`define IHP_WIN_MASK_64K 16'hFFFF

`endif

// *** ihp_pkg.sv ***
// types shared by the idle/halt power controller
package ihp_pkg;

	// power state of the core
	typedef enum logic [1:0] {
		IHP_RUN,
		IHP_IDLE,
		IHP_HALT,
		IHP_START
	} ihp_state_t;

	// clock mode decoded from the clock control bits
	typedef enum logic [1:0] {
		IHP_MODE_HS,
		IHP_MODE_DC,
		IHP_MODE_LS
	} ihp_mode_t;

endpackage : ihp_pkg

// *** ihp_idle_timer.sv ***
// idle timer: free down counter with window tap and load for the start-up delay
`timescale 1ns/1ps
`include "ihp_map.svh"

module ihp_idle_timer #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	// count control
	input wire logic tick,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	input wire logic [2:0] winSel,
	// events
	output logic tapEvent,
	output logic wrapEvent
);

	////////////////////////////////////////////////////////////////////////////////
	// counter state
	logic [WIDTH-1:0] count; // current count, value after reset is of no meaning
	logic [WIDTH-1:0] next_count; // next count
	logic [15:0] winMask; // low bits that must be zero at a window boundary

	// window mask from the window select field
	always_comb begin
		case (winSel)
			3'h0: winMask = `IHP_WIN_MASK_4K;
			3'h1: winMask = `IHP_WIN_MASK_8K;
			3'h2: winMask = `IHP_WIN_MASK_16K;
			3'h3: winMask = `IHP_WIN_MASK_32K;
			default: winMask = `IHP_WIN_MASK_64K;
		endcase
	end

	// next count and events, load wins over a tick
	always_comb begin
		next_count = count;
		tapEvent = 1'b0;
		wrapEvent = 1'b0;
		if (load) begin
			next_count = loadValue;
		end else if (tick) begin
			// the window bit toggles as the masked low bits borrow
			tapEvent = ((count & WIDTH'(winMask)) == '0);
			wrapEvent = (count == '0);
			next_count = count - WIDTH'(1);
		end
	end

	// count register
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			count <= '0;
		end else if (ce) begin
			count <= next_count;
		end
	end

endmodule : ihp_idle_timer

// *** ihp_power_ctrl.sv ***
// idle and halt power mode controller with dual clock mode control
//
// How it works
// - idle bit stops execution, idle timer keeps running
// - five idle windows 4k to 64k cycles
// - idle timer counts instruction clock in high speed
// - window toggle sets pending, interrupt, idle exit
// - interrupt serviced after current instruction completes
// - reset or wake-up event also ends idle
// - reset selects the 4k window
// - idle timer hidden from software, free running
// - interrupt only when enable set, pending always
// - halt bit stops core, dual clock keeps low
// - reset forces high speed mode from halt
// - wake-up transition ends halt
// - wake from halt waits 256 instruction cycles, none in low speed mode
// - instruction clock is fifth, start-up count gated by amplitude
// - after start-up in dual clock mode timer returns to low clock
// - halt disable option ignores halt requests
// - dual clock idle times on low clock
// - code 01 forces low speed mode
// - illegal clock bits cause automatic reset
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ihp_map.svh"

module ihp_power_ctrl #(
	parameter int TIMER_WIDTH = 16
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// oscillator and wake-up inputs
	input wire logic lowClkTick,
	input wire logic oscAmpOk,
	input wire logic wakeEvent,
	input wire logic haltDisable,
	input wire logic secondTimerHighSpeed,
	input wire logic secondTimerRunInIdle,
	// core and clock outputs
	output logic coreTick,
	output logic execEnable,
	output logic idleInterrupt,
	output logic idleActive,
	output logic haltActive,
	output logic highOscRun,
	output logic lowOscRun,
	output logic idleTimerOnLow,
	output logic secondTimerRun,
	output logic selfReset,
	output ihp_pkg::ihp_mode_t modeState
);
	import ihp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic rstAll; // external or automatic reset
	logic [2:0] divCnt; // instruction clock divider
	logic [2:0] next_divCnt; // next divider value
	logic instrTick; // one pulse per five oscillator cycles
	logic coreSrcLow; // core clock taken from the low clock
	logic next_coreSrcLow; // next core source
	logic srcTick; // tick of the selected core source
	logic [7:0] idle_timer_control_register; // idle timer control register
	logic [7:0] next_idle_timer_control_register; // next control register
	logic intEnable; // idle interrupt enable
	logic next_intEnable; // next enable
	logic pending; // idle pending flag
	logic next_pending; // next pending flag
	logic idleReq; // idle bit written, waiting for instruction boundary
	logic next_idleReq; // next idle request
	logic haltReq; // halt bit written, waiting for instruction boundary
	logic next_haltReq; // next halt request
	logic [7:0] next_rdData; // read data for the next cycle
	logic next_selfReset; // illegal clock bits seen
	ihp_state_t state; // power state
	ihp_state_t next_state; // next power state
	ihp_mode_t mode; // decoded clock mode
	logic clkLegal; // clock bits hold a valid pattern
	logic tmrTick; // idle timer clock enable
	logic tmrLoad; // load start-up count
	logic tapEvent; // selected window boundary
	logic wrapEvent; // start-up count underflow
	logic wrSel; // write strobe for this block
	logic [3:0] clkBits; // the four clock control bits

	// external reset or the automatic reset from an illegal clock pattern
	assign rstAll = !nrst || selfReset;
	assign wrSel = regWrite && ce;
	assign clkBits = idle_timer_control_register[`IHP_IT_LOW_OSC_ON:`IHP_IT_CORE_CLK_SEL];

	////////////////////////////////////////////////////////////////////////////////
	// clock mode decode

	// dual clock enable and core select give the mode, 01 forces low speed
	always_comb begin
		case ({idle_timer_control_register[`IHP_IT_DUAL_CLOCK_EN], idle_timer_control_register[`IHP_IT_CORE_CLK_SEL]})
			2'b00: mode = IHP_MODE_HS;
			2'b10: mode = IHP_MODE_DC;
			2'b11: mode = IHP_MODE_LS;
			default: mode = IHP_MODE_LS;
		endcase
	end

	// only five patterns keep a clock on the core
	always_comb begin
		case (clkBits)
			`IHP_CLK_HS, `IHP_CLK_HS_TO_DC, `IHP_CLK_DC: clkLegal = 1'b1;
			`IHP_CLK_DC_TO_LS, `IHP_CLK_LS: clkLegal = 1'b1;
			default: clkLegal = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// instruction clock and core clock source

	// divide the oscillator by five while the high oscillator runs
	always_comb begin
		next_divCnt = divCnt;
		if (highOscRun) begin
			next_divCnt = (divCnt == `IHP_INSTR_DIV_LAST) ? 3'h0 : divCnt + 3'h1;
		end
		instrTick = highOscRun && (divCnt == `IHP_INSTR_DIV_LAST);
		srcTick = coreSrcLow ? lowClkTick : instrTick;
		// change source only when neither clock pulses, so no pulse is cut
		next_coreSrcLow = coreSrcLow;
		if (!instrTick && !lowClkTick) begin
			next_coreSrcLow = (mode == IHP_MODE_LS);
		end
	end

	// divider and source registers
	always_ff @(posedge sys_clk) begin
		if (rstAll) begin
			divCnt <= 3'h0;
			coreSrcLow <= 1'b0;
		end else if (ce) begin
			divCnt <= next_divCnt;
			coreSrcLow <= next_coreSrcLow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// idle timer

	// timer clock choice by state and mode
	always_comb begin
		// load on the same wake-up that leads into start-up, without going through next_state
		tmrLoad = (state == IHP_HALT) && wakeEvent && (mode != IHP_MODE_LS);
		case (state)
			IHP_START: tmrTick = instrTick && oscAmpOk;
			IHP_HALT: tmrTick = 1'b0;
			default: begin
				// high speed counts instructions, else the low clock
				tmrTick = (mode == IHP_MODE_HS) ? instrTick : lowClkTick;
			end
		endcase
	end

	// free running timer, no software access to its count
	ihp_idle_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.tick(tmrTick),
		.load(tmrLoad),
		.loadValue(TIMER_WIDTH'(`IHP_STARTUP_COUNT - 16'h0001)),
		.winSel(idle_timer_control_register[`IHP_IT_WIN_MSB:`IHP_IT_WIN_LSB]),
		.tapEvent(tapEvent),
		.wrapEvent(wrapEvent)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registers and power state

	// register writes, requests and state changes
	always_comb begin
		next_idle_timer_control_register = idle_timer_control_register;
		next_intEnable = intEnable;
		next_pending = pending;
		next_idleReq = idleReq;
		next_haltReq = haltReq;
		next_state = state;
		next_rdData = 8'h00;
		next_selfReset = !clkLegal;
		// software writes
		if (wrSel) begin
			case (regAddr)
				`IHP_ADDR_PORTG: begin
					if (regWrData[`IHP_PG_IDLE]) begin
						next_idleReq = 1'b1;
					end
					if (regWrData[`IHP_PG_HALT] && !haltDisable) begin
						next_haltReq = 1'b1;
					end
				end
				`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER: begin
					next_idle_timer_control_register = regWrData & `IHP_IT_WRITE_MASK;
				end
				`IHP_ADDR_INTERRUPT_CONTROL_REGISTER: begin
					next_intEnable = regWrData[`IHP_IC_ENABLE];
					// writing zero clears the pending flag
					if (!regWrData[`IHP_IC_PENDING]) begin
						next_pending = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// a window boundary sets pending, winning over a clear
		if (tapEvent && state != IHP_START) begin
			next_pending = 1'b1;
		end
		// power state sequence
		case (state)
			IHP_RUN: begin
				// entry at the next instruction boundary, halt first
				if (srcTick && haltReq) begin
					next_state = IHP_HALT;
					next_haltReq = 1'b0;
					next_idleReq = 1'b0;
				end else if (srcTick && idleReq) begin
					next_state = IHP_IDLE;
					next_idleReq = 1'b0;
				end
			end
			IHP_IDLE: begin
				if (tapEvent || wakeEvent) begin
					next_state = IHP_RUN;
				end
			end
			IHP_HALT: begin
				if (wakeEvent) begin
					// low speed keeps its clock, others wait for start-up
					next_state = (mode == IHP_MODE_LS) ? IHP_RUN : IHP_START;
				end
			end
			IHP_START: begin
				if (wrapEvent) begin
					next_state = IHP_RUN;
				end
			end
			default: begin
				next_state = IHP_RUN;
			end
		endcase
		// read data, shown in the cycle after the strobe
		if (regRead && ce) begin
			case (regAddr)
				`IHP_ADDR_PORTG: next_rdData = {haltActive, idleActive, 6'h00};
				`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER: next_rdData = idle_timer_control_register;
				`IHP_ADDR_INTERRUPT_CONTROL_REGISTER: next_rdData = {6'h00, pending, intEnable};
				`IHP_ADDR_STATUS: next_rdData = {4'h0, 2'(mode), 2'(state)};
				default: next_rdData = 8'h00;
			endcase
		end
	end

	// register and state flops, reset restores high speed and the 4k window
	always_ff @(posedge sys_clk) begin
		if (rstAll) begin
			idle_timer_control_register <= `IHP_IT_RESET;
			intEnable <= 1'b0;
			pending <= 1'b0;
			idleReq <= 1'b0;
			haltReq <= 1'b0;
			state <= IHP_RUN;
			regRdData <= 8'h00;
		end else if (ce) begin
			idle_timer_control_register <= next_idle_timer_control_register;
			intEnable <= next_intEnable;
			pending <= next_pending;
			idleReq <= next_idleReq;
			haltReq <= next_haltReq;
			state <= next_state;
			regRdData <= next_rdData;
		end
	end

	// automatic reset pulse of one cycle, its flop reset only by the external reset
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			selfReset <= 1'b0;
		end else if (ce) begin
			selfReset <= next_selfReset && !selfReset;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs

	// values of the outputs for the next cycle
	logic next_coreTick; // core clock pulse
	logic next_execEnable; // program execution allowed
	logic next_idleInterrupt; // idle timer interrupt request
	logic next_highOscRun; // high oscillator runs
	logic next_lowOscRun; // low oscillator runs
	logic next_idleTimerOnLow; // idle timer on the low clock
	logic next_secondTimerRun; // second timer clocked

	// outputs follow the next state so they line up with it
	always_comb begin
		next_execEnable = (next_state == IHP_RUN);
		next_coreTick = (next_state == IHP_RUN) && (state == IHP_RUN) && srcTick;
		// interrupt raised only when enabled; core finishes its instruction first
		next_idleInterrupt = next_pending && next_intEnable;
		// high oscillator stops in halt unless woken into start-up
		next_highOscRun = next_idle_timer_control_register[`IHP_IT_HIGH_OSC_ON] && (next_state != IHP_HALT);
		next_lowOscRun = next_idle_timer_control_register[`IHP_IT_LOW_OSC_ON];
		next_idleTimerOnLow = (next_state != IHP_START) && (mode != IHP_MODE_HS);
		// second timer runs in idle only with both idle-run bits
		next_secondTimerRun = next_highOscRun && (next_state != IHP_HALT) &&
			((next_state != IHP_IDLE) || (secondTimerHighSpeed && secondTimerRunInIdle));
	end

	// output flops
	always_ff @(posedge sys_clk) begin
		if (rstAll) begin
			coreTick <= 1'b0;
			execEnable <= 1'b0;
			idleInterrupt <= 1'b0;
			idleActive <= 1'b0;
			haltActive <= 1'b0;
			highOscRun <= 1'b1;
			lowOscRun <= 1'b0;
			idleTimerOnLow <= 1'b0;
			secondTimerRun <= 1'b0;
			modeState <= IHP_MODE_HS;
		end else if (ce) begin
			coreTick <= next_coreTick;
			execEnable <= next_execEnable;
			idleInterrupt <= next_idleInterrupt;
			idleActive <= (next_state == IHP_IDLE);
			haltActive <= (next_state == IHP_HALT) || (next_state == IHP_START);
			highOscRun <= next_highOscRun;
			lowOscRun <= next_lowOscRun;
			idleTimerOnLow <= next_idleTimerOnLow;
			secondTimerRun <= next_secondTimerRun;
			modeState <= mode;
		end
	end

endmodule : ihp_power_ctrl

// *** ihp_power_ctrl_sva.sv ***
// concurrent checks on the ports of the idle/halt power controller
`timescale 1ns/1ps
`include "ihp_map.svh"

module ihp_power_ctrl_sva #(
	parameter int TIMER_WIDTH = 16
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// oscillator and wake-up inputs
	input wire logic lowClkTick,
	input wire logic oscAmpOk,
	input wire logic wakeEvent,
	input wire logic haltDisable,
	input wire logic secondTimerHighSpeed,
	input wire logic secondTimerRunInIdle,
	// core and clock outputs
	input wire logic coreTick,
	input wire logic execEnable,
	input wire logic idleInterrupt,
	input wire logic idleActive,
	input wire logic haltActive,
	input wire logic highOscRun,
	input wire logic lowOscRun,
	input wire logic idleTimerOnLow,
	input wire logic secondTimerRun,
	input wire logic selfReset,
	input wire ihp_pkg::ihp_mode_t modeState
);
	import ihp_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////////
	// idle request written while running in high speed mode
	sequence s_idle_req;
		regWrite && ce && regAddr == `IHP_ADDR_PORTG && regWrData == 8'h40 && execEnable
			&& modeState == IHP_MODE_HS;
	endsequence
	// wake-up seen while idle
	sequence s_idle_wake;
		idleActive && wakeEvent && ce;
	endsequence

	// read data only stand after a read strobe
	a_rd_data_idle: assert property (regRdData != 8'h00 |-> $past(regRead))
		else $error("read data without read strobe");
	// unmapped addresses read as zero
	a_rd_unmapped: assert property (regRead && regAddr > 4'h3 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	// reserved bit 3 of the window register reads zero
	a_idle_timer_control_register_bit3: assert property (regRead && regAddr == `IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER |=> !regRdData[3])
		else $error("reserved window bit read back");
	// execution stops while idle or halted
	a_exec_stopped: assert property (idleActive || haltActive |-> !execEnable)
		else $error("execution while idle or halted");
	// core ticks only while executing
	a_tick_run: assert property (coreTick |-> execEnable)
		else $error("core tick outside run");
	// halt option disabled keeps the core out of halt
	a_halt_ignored: assert property (haltDisable && !haltActive |=> !haltActive)
		else $error("halt entered while disabled");
	// idle entry at the next instruction tick
	a_idle_entry: assert property (s_idle_req |-> ##[1:8] idleActive)
		else $error("idle not entered");
	// wake-up ends idle
	a_wake_idle: assert property (s_idle_wake |-> ##[1:2] execEnable)
		else $error("wake-up did not end idle");
	// reset leaves the core in high speed mode
	a_reset_mode: assert property ($rose(nrst) |-> modeState == IHP_MODE_HS && highOscRun
		&& !haltActive)
		else $error("reset did not restore high speed");
	// automatic reset is one pulse and restores high speed
	a_self_reset: assert property (selfReset |=> !selfReset && modeState == IHP_MODE_HS
		&& highOscRun)
		else $error("automatic reset wrong");
endmodule : ihp_power_ctrl_sva

bind ihp_power_ctrl ihp_power_ctrl_sva #(.TIMER_WIDTH(TIMER_WIDTH)) u_sva (
	.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.lowClkTick(lowClkTick), .oscAmpOk(oscAmpOk), .wakeEvent(wakeEvent),
	.haltDisable(haltDisable), .secondTimerHighSpeed(secondTimerHighSpeed),
	.secondTimerRunInIdle(secondTimerRunInIdle), .coreTick(coreTick),
	.execEnable(execEnable), .idleInterrupt(idleInterrupt), .idleActive(idleActive),
	.haltActive(haltActive), .highOscRun(highOscRun), .lowOscRun(lowOscRun),
	.idleTimerOnLow(idleTimerOnLow), .secondTimerRun(secondTimerRun),
	.selfReset(selfReset), .modeState(modeState)
);

// *** ihp_power_ctrl_tb_top.sv ***
// self-checking testbench of the idle/halt power controller
`timescale 1ns/1ps
`include "ihp_map.svh"

module ihp_power_ctrl_tb_top;
	import ihp_pkg::*;

	// stimulus and observed signals
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1; // held running
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic lowClkTick = 1'b0;
	logic oscAmpOk = 1'b1;
	logic wakeEvent = 1'b0;
	logic haltDisable = 1'b0;
	logic secondTimerHighSpeed = 1'b1;
	logic secondTimerRunInIdle = 1'b1;
	logic [7:0] regRdData;
	logic coreTick, execEnable, idleInterrupt, idleActive, haltActive;
	logic highOscRun, lowOscRun, idleTimerOnLow, secondTimerRun, selfReset;
	ihp_mode_t modeState;
	int errors = 0;
	int n_tests = 0;
	int cycleCnt = 0; // free cycle count for durations
	int c0, c1, cyc;

	ihp_power_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.lowClkTick(lowClkTick), .oscAmpOk(oscAmpOk), .wakeEvent(wakeEvent),
		.haltDisable(haltDisable), .secondTimerHighSpeed(secondTimerHighSpeed),
		.secondTimerRunInIdle(secondTimerRunInIdle), .coreTick(coreTick),
		.execEnable(execEnable), .idleInterrupt(idleInterrupt), .idleActive(idleActive),
		.haltActive(haltActive), .highOscRun(highOscRun), .lowOscRun(lowOscRun),
		.idleTimerOnLow(idleTimerOnLow), .secondTimerRun(secondTimerRun),
		.selfReset(selfReset), .modeState(modeState));

	////////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// low speed tick every 16 cycles, plus cycle count
	always @(posedge sys_clk) begin
		cycleCnt <= cycleCnt + 1;
		lowClkTick <= (cycleCnt % 16) == 15;
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// one-cycle register write
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask : wr

	// one-cycle read, data checked in the following cycle
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		chk({24'h0000_00, regRdData}, {24'h0000_00, exp}, "read data");
	endtask : rd

	// bounded wait: 0 idle, 1 executing, 2 halted, 3 automatic reset
	task wait_for(input int sel, input int lim, output int n);
		n = 0;
		#1;
		while (!(sel == 0 ? idleActive === 1'b1 : sel == 1 ? execEnable === 1'b1 :
			sel == 2 ? haltActive === 1'b1 : selfReset === 1'b1) && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			errors++;
			$display("MISMATCH t=%0t wait %0d timed out", $time, sel);
		end
	endtask : wait_for

	// one wake-up pulse
	task wake;
		@(posedge sys_clk);
		wakeEvent <= 1'b1;
		@(posedge sys_clk);
		wakeEvent <= 1'b0;
	endtask : wake

	// counts and verdict
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#600_000;
		errors++;
		$display("MISMATCH t=%0t run too long", $time);
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h40);
		rd(`IHP_ADDR_STATUS, 8'h00);
		rd(4'h9, 8'h00);
		// first idle with interrupt enabled
		wr(`IHP_ADDR_INTERRUPT_CONTROL_REGISTER, 8'h01);
		wr(`IHP_ADDR_PORTG, 8'h40);
		wait_for(0, 20, cyc);
		chk({31'h0, secondTimerRun}, 32'h1, "second timer idle run");
		wait_for(1, 25000, cyc);
		c0 = cycleCnt;
		chk({31'h0, idleInterrupt}, 32'h1, "idle interrupt");
		rd(`IHP_ADDR_INTERRUPT_CONTROL_REGISTER, 8'h03);
		// synchronised idle with interrupt off: one 4k window exactly
		wr(`IHP_ADDR_INTERRUPT_CONTROL_REGISTER, 8'h00);
		wr(`IHP_ADDR_PORTG, 8'h40);
		wait_for(0, 20, cyc);
		wait_for(1, 25000, cyc);
		chk(cycleCnt - c0, 32'd20480, "window length");
		chk({31'h0, idleInterrupt}, 32'h0, "masked interrupt");
		rd(`IHP_ADDR_INTERRUPT_CONTROL_REGISTER, 8'h02);
		// wake-up ends idle, second timer stopped without its idle-run bit
		@(posedge sys_clk);
		secondTimerRunInIdle <= 1'b0;
		wr(`IHP_ADDR_INTERRUPT_CONTROL_REGISTER, 8'h00);
		wr(`IHP_ADDR_PORTG, 8'h40);
		wait_for(0, 20, cyc);
		chk({31'h0, secondTimerRun}, 32'h0, "second timer stopped in idle");
		wake();
		wait_for(1, 3, cyc);
		// window select field for every window, reserved bit dropped
		for (int w = 0; w < 5; w++) begin
			wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h40 | w[7:0]);
			rd(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h40 | w[7:0]);
		end
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h48);
		rd(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h40);
		// halt option disabled, core ticks counted meanwhile
		@(posedge sys_clk);
		haltDisable <= 1'b1;
		wr(`IHP_ADDR_PORTG, 8'h80);
		cyc = 0;
		repeat (20) begin
			@(posedge sys_clk);
			#1;
			cyc += int'(coreTick === 1'b1);
		end
		chk(cyc, 32'd4, "one core tick per five cycles");
		chk({31'h0, haltActive}, 32'h0, "halt ignored");
		@(posedge sys_clk);
		haltDisable <= 1'b0;
		// high speed to dual clock
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'hC0);
		repeat (10) @(posedge sys_clk);
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'hE0);
		rd(`IHP_ADDR_STATUS, 8'h04);
		chk({31'h0, lowOscRun}, 32'h1, "low osc on");
		// dual clock halt, wake-up, gated start-up delay
		@(posedge sys_clk);
		oscAmpOk <= 1'b0;
		wr(`IHP_ADDR_PORTG, 8'h80);
		wait_for(2, 20, cyc);
		chk({30'h0, highOscRun, lowOscRun}, 32'h1, "halt clocks");
		wake();
		repeat (200) @(posedge sys_clk);
		#1;
		chk({31'h0, execEnable}, 32'h0, "start-up gated");
		@(posedge sys_clk);
		oscAmpOk <= 1'b1;
		c1 = cycleCnt;
		wait_for(1, 2000, cyc);
		chk({31'h0, cycleCnt - c1 >= 1280 && cycleCnt - c1 <= 1290}, 32'h1,
			"start-up length");
		chk({31'h0, idleTimerOnLow}, 32'h1, "timer back on low clock");
		// dual clock to low speed
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'hF0);
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'hB0);
		#1;
		chk({30'h0, modeState}, {30'h0, IHP_MODE_LS}, "low speed mode");
		// low speed back to dual clock
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'hF0);
		repeat (10) @(posedge sys_clk);
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'hE0);
		@(posedge sys_clk);
		#1;
		chk({30'h0, modeState}, {30'h0, IHP_MODE_DC}, "dual clock again");
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk({30'h0, modeState}, {30'h0, IHP_MODE_HS}, "reset mode");
		rd(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h40);
		// illegal clock bits cause automatic reset
		wr(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h10);
		wait_for(3, 5, cyc);
		chk({30'h0, modeState}, {30'h0, IHP_MODE_LS}, "code 01 forces low speed");
		rd(`IHP_ADDR_IDLE_TIMER_CONTROL_REGISTER, 8'h40);
		print_verdict();
	end
endmodule : ihp_power_ctrl_tb_top
